//--- core/xcvr_cfg_pkg.sv
// Package of offsets, field positions, reset values and encodings for the mode configuration registers
package xcvr_cfg_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam logic [31:0] general_configuration_idx = 32'h0000_0000;
  localparam logic [31:0] data_and_modulation_configuration_idx = 32'h0000_0001;
  localparam logic [31:0] addr_general_configuration = general_configuration_idx << 2;
  localparam logic [31:0] addr_data_and_modulation_configuration = data_and_modulation_configuration_idx << 2;
  localparam int reg_count = 2;
  localparam int reg_width = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] general_configuration_reset = 8'h28;
  localparam logic [7:0] data_and_modulation_configuration_reset = 8'h88;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int chip_operating_mode_lsb = 5;
  localparam int frequency_band_select_lsb = 3;
  localparam int vco_tune_trim_lsb = 1;
  localparam int pll_divider_set_select_bit = 0;
  localparam int modulation_type_select_lsb = 6;
  localparam int data_op_mode_low_bit = 5;
  localparam int onoff_threshold_type_lsb = 3;
  localparam int data_op_mode_high_bit = 2;
  localparam int intermediate_freq_gain_lsb = 0;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] mode_sleep = 3'h0;
  localparam logic [2:0] mode_standby = 3'h1;
  localparam logic [2:0] mode_synth = 3'h2;
  localparam logic [2:0] mode_receive = 3'h3;
  localparam logic [2:0] mode_transmit = 3'h4;
  localparam logic [1:0] band_alt = 2'h2;
  localparam logic [1:0] band_reserved = 2'h3;
  localparam logic [1:0] modulation_fsk = 2'h2;
  localparam logic [1:0] modulation_ook = 2'h1;

  typedef enum logic [2:0] {
    op_sleep, op_standby, op_synth, op_receive, op_transmit, op_undefined
  } op_mode_t;

  typedef enum logic [1:0] {
    data_continuous, data_buffered, data_packet
  } data_mode_t;
endpackage : xcvr_cfg_pkg

//--- core/cfg_byte_store.sv
// Small register file holding the configuration bytes, with registered read data
`timescale 1ns/10ps
`default_nettype none
module cfg_byte_store
  import xcvr_cfg_pkg::*;
#(
  parameter int depth = reg_count,
  parameter int width = reg_width
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [$clog2(depth)-1:0] wr_idx,
  input wire logic [$clog2(depth)-1:0] rd_idx,
  input wire logic [width-1:0] wr_data,
  output logic [width-1:0] rd_data,
  output logic [depth*width-1:0] all_data
);
  logic [width-1:0] store [depth];
  logic [width-1:0] next_store [depth];
  logic [width-1:0] next_rd_data;

  // ---------------------------------------------------------------
  // Per entry storage, reset to the power-on values
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < depth; g++) begin : g_entry
      localparam logic [width-1:0] init_value = (g == 0) ? general_configuration_reset :
                                                data_and_modulation_configuration_reset;
      // Whole byte replaced in one write
      always_comb begin
        next_store[g] = store[g];
        if (wr_en && (wr_idx == g)) begin
          next_store[g] = wr_data;
        end
      end
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          store[g] <= init_value;
        end else begin
          store[g] <= next_store[g];
        end
      end
      assign all_data[g*width +: width] = store[g];
    end
  endgenerate

  // Read port, registered so data come straight from a flip-flop
  always_comb begin
    next_rd_data = rd_data;
    if (rd_en) begin
      next_rd_data = store[rd_idx];
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule : cfg_byte_store
`default_nettype wire

//--- core/transceiver_mode_config_regs.sv
// AHB-Lite slave holding the operating mode and data/modulation configuration registers
// Contract
// - General configuration at offset 0x00, eight bits read/write, resets to 0x28.
// - Bits 7..5 pick mode: sleep, standby, synthesizer, receive, transmit.
// - Bits 4..3 pick the band; 10 is the alternate band, 11 reserved.
// - Bits 2..1 trim VCO tuning; 11 is +180 mV, 10 +120 mV, reset 00.
// - Bit 0 set uses divider group two, clear uses group one.
// - Register 0x01 bits 7..6: 10 FSK default, 01 OOK, others reserved.
// - Data mode bits 2 and 5: continuous, buffered, or packet when bit 2 set.
`timescale 1ns/10ps
`default_nettype none
module transceiver_mode_config_regs
  import xcvr_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [2:0] chip_operating_mode,
  output logic op_mode_valid,
  output logic op_sleep_en,
  output logic op_standby_en,
  output logic op_synth_en,
  output logic op_receive_en,
  output logic op_transmit_en,
  output logic [1:0] frequency_band_select,
  output logic band_alt_en,
  output logic band_reserved_flag,
  output logic [1:0] vco_tune_trim,
  output logic pll_divider_group_one,
  output logic pll_divider_group_two,
  output logic [1:0] modulation_type_select,
  output logic fsk_en,
  output logic ook_en,
  output logic modulation_reserved_flag,
  output logic [1:0] onoff_threshold_type,
  output logic [1:0] intermediate_freq_gain,
  output logic data_continuous_en,
  output logic data_buffered_en,
  output logic data_packet_en
);
  // ---------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------
  logic dp_write;
  logic dp_read;
  logic dp_idx;
  logic dp_mapped;
  logic next_dp_write;
  logic next_dp_read;
  logic next_dp_idx;
  logic next_dp_mapped;
  logic rd_pending;
  logic next_rd_pending;
  logic rd_mapped;
  logic next_rd_mapped;
  logic [7:0] rd_byte;
  logic [2*reg_width-1:0] all_regs;
  logic [7:0] gen_q;
  logic [7:0] dmc_q;
  logic addr_ok;
  logic access;

  // Transfers of any size (hsize ignored) to the first two aligned words are mapped
  assign access = hsel && hready && htrans[1];
  assign addr_ok = (haddr == addr_general_configuration) || (haddr == addr_data_and_modulation_configuration);

  // Decode an address phase into a pending data phase
  always_comb begin
    next_dp_write = 1'b0;
    next_dp_read = 1'b0;
    next_dp_idx = dp_idx;
    next_dp_mapped = 1'b0;
    if (access) begin
      next_dp_write = hwrite;
      next_dp_read = !hwrite;
      next_dp_idx = haddr[2];
      next_dp_mapped = addr_ok;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_idx <= 1'b0;
      dp_mapped <= 1'b0;
    end else begin
      dp_write <= next_dp_write;
      dp_read <= next_dp_read;
      dp_idx <= next_dp_idx;
      dp_mapped <= next_dp_mapped;
    end
  end

  // ---------------------------------------------------------------
  // Read wait states: the store's read data and hrdata are both
  // registered, so a read spends two cycles with hreadyout low.
  // Writes take no wait.
  // ---------------------------------------------------------------
  always_comb begin
    next_rd_pending = 1'b0;
    next_rd_mapped = rd_mapped;
    if (dp_read && !rd_pending) begin
      next_rd_pending = 1'b1;
      next_rd_mapped = dp_mapped;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_pending <= 1'b0;
      rd_mapped <= 1'b0;
    end else begin
      rd_pending <= next_rd_pending;
      rd_mapped <= next_rd_mapped;
    end
  end

  // Store, written in the data phase with the low byte of hwdata
  cfg_byte_store #(
    .depth(reg_count),
    .width(reg_width)
  ) u_store (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(dp_write && dp_mapped),
    .rd_en(dp_read && !rd_pending),
    .wr_idx(dp_idx),
    .rd_idx(dp_idx),
    .wr_data(hwdata[7:0]),
    .rd_data(rd_byte),
    .all_data(all_regs)
  );
  assign gen_q = all_regs[7:0];
  assign dmc_q = all_regs[15:8];

  // Bus outputs, all registered; unmapped reads return zero, response always OKAY
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  always_comb begin
    next_hreadyout = !(next_dp_read || (dp_read && !rd_pending)) || rd_pending;
    next_hrdata = hrdata;
    if (rd_pending) begin
      next_hrdata = rd_mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
  // hreadyout stays low until hrdata holds the byte, so the master never takes stale data
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
    end
  end

  // ---------------------------------------------------------------
  // Field decode toward the radio; registered so every output is a flop.
  // Decode follows the store, so a write is in force one cycle later.
  // ---------------------------------------------------------------
  logic [2:0] mode_f;
  logic [1:0] mod_f;
  assign mode_f = gen_q[chip_operating_mode_lsb +: 3];
  assign mod_f = dmc_q[modulation_type_select_lsb +: 2];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chip_operating_mode <= general_configuration_reset[chip_operating_mode_lsb +: 3];
      op_mode_valid <= 1'b1;
      op_sleep_en <= 1'b0;
      op_standby_en <= 1'b1;
      op_synth_en <= 1'b0;
      op_receive_en <= 1'b0;
      op_transmit_en <= 1'b0;
      frequency_band_select <= general_configuration_reset[frequency_band_select_lsb +: 2];
      band_alt_en <= 1'b0;
      band_reserved_flag <= 1'b0;
      vco_tune_trim <= general_configuration_reset[vco_tune_trim_lsb +: 2];
      pll_divider_group_one <= 1'b1;
      pll_divider_group_two <= 1'b0;
      modulation_type_select <= data_and_modulation_configuration_reset[modulation_type_select_lsb +: 2];
      fsk_en <= 1'b1;
      ook_en <= 1'b0;
      modulation_reserved_flag <= 1'b0;
      onoff_threshold_type <= data_and_modulation_configuration_reset[onoff_threshold_type_lsb +: 2];
      intermediate_freq_gain <= data_and_modulation_configuration_reset[intermediate_freq_gain_lsb +: 2];
      data_continuous_en <= 1'b1;
      data_buffered_en <= 1'b0;
      data_packet_en <= 1'b0;
    end else begin
      chip_operating_mode <= mode_f;
      // Reserved mode codes enable no mode at all; software is expected to avoid them
      op_mode_valid <= (mode_f <= mode_transmit);
      op_sleep_en <= (mode_f == mode_sleep);
      op_standby_en <= (mode_f == mode_standby);
      op_synth_en <= (mode_f == mode_synth);
      op_receive_en <= (mode_f == mode_receive);
      op_transmit_en <= (mode_f == mode_transmit);
      frequency_band_select <= gen_q[frequency_band_select_lsb +: 2];
      band_alt_en <= (gen_q[frequency_band_select_lsb +: 2] == band_alt);
      band_reserved_flag <= (gen_q[frequency_band_select_lsb +: 2] == band_reserved);
      vco_tune_trim <= gen_q[vco_tune_trim_lsb +: 2];
      pll_divider_group_one <= !gen_q[pll_divider_set_select_bit];
      pll_divider_group_two <= gen_q[pll_divider_set_select_bit];
      modulation_type_select <= mod_f;
      fsk_en <= (mod_f == modulation_fsk);
      ook_en <= (mod_f == modulation_ook);
      modulation_reserved_flag <= (mod_f != modulation_fsk) && (mod_f != modulation_ook);
      onoff_threshold_type <= dmc_q[onoff_threshold_type_lsb +: 2];
      intermediate_freq_gain <= dmc_q[intermediate_freq_gain_lsb +: 2];
      // High bit alone decides packet mode; low bit only matters when high is clear
      data_packet_en <= dmc_q[data_op_mode_high_bit];
      data_buffered_en <= !dmc_q[data_op_mode_high_bit] && dmc_q[data_op_mode_low_bit];
      data_continuous_en <= !dmc_q[data_op_mode_high_bit] && !dmc_q[data_op_mode_low_bit];
    end
  end
endmodule : transceiver_mode_config_regs
`default_nettype wire

//--- test/mode_cfg_sva.sv
// Checker for the mode configuration register block, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module mode_cfg_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [2:0] chip_operating_mode,
  input wire logic op_mode_valid,
  input wire logic op_sleep_en,
  input wire logic op_standby_en,
  input wire logic op_synth_en,
  input wire logic op_receive_en,
  input wire logic op_transmit_en,
  input wire logic pll_divider_group_one,
  input wire logic pll_divider_group_two,
  input wire logic [1:0] modulation_type_select,
  input wire logic fsk_en,
  input wire logic ook_en,
  input wire logic data_continuous_en,
  input wire logic data_buffered_en,
  input wire logic data_packet_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Reads take two wait states, writes none
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  // Mode follows the written byte three edges after the address phase
  mode_update_a: assert property (hsel && hready && htrans[1] && hwrite && haddr == 32'h0 ##1 1'b1
    |-> ##2 chip_operating_mode == $past(hwdata[7:5], 2)) else $error("mode not updated by write");
  mode_hold_a: assert property ((!(hsel && hready && htrans[1] && hwrite))[*4] ##1 1'b1
    |-> $stable(chip_operating_mode)) else $error("mode changed without write");
  mode_decode_a: assert property ({op_transmit_en, op_receive_en, op_synth_en, op_standby_en, op_sleep_en}
    == (chip_operating_mode <= 3'h4 ? 5'h01 << chip_operating_mode : 5'h00)
    && op_mode_valid == (chip_operating_mode <= 3'h4)) else $error("mode decode wrong");
  pll_group_a: assert property (pll_divider_group_two != pll_divider_group_one)
    else $error("divider group select wrong");
  mod_decode_a: assert property (fsk_en == (modulation_type_select == 2'h2)
    && ook_en == (modulation_type_select == 2'h1)) else $error("modulation decode wrong");
  data_onehot_a: assert property ($onehot({data_continuous_en, data_buffered_en, data_packet_en}))
    else $error("data mode not one-hot");
  rdata_upper_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("read data above byte nonzero");
endmodule : mode_cfg_sva
bind transceiver_mode_config_regs mode_cfg_sva u_sva (.core_clk(core_clk), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .chip_operating_mode(chip_operating_mode), .op_mode_valid(op_mode_valid),
  .op_sleep_en(op_sleep_en), .op_standby_en(op_standby_en), .op_synth_en(op_synth_en),
  .op_receive_en(op_receive_en), .op_transmit_en(op_transmit_en), .pll_divider_group_one(pll_divider_group_one),
  .pll_divider_group_two(pll_divider_group_two), .modulation_type_select(modulation_type_select),
  .fsk_en(fsk_en), .ook_en(ook_en), .data_continuous_en(data_continuous_en),
  .data_buffered_en(data_buffered_en), .data_packet_en(data_packet_en));
`default_nettype wire

//--- test/tb_top.sv
// Self-checking testbench for the mode configuration register block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import xcvr_cfg_pkg::*;
;
  logic core_clk, reset, hsel, hwrite, rdy, hresp, mv, sl, sb, sy, rx, tx, b_alt, b_res, g1, g2, fsk, ook, mres;
  logic dc, db, dp;
  logic [1:0] htrans, band, trim, mod, thr, gain;
  logic [2:0] com;
  logic [31:0] haddr, hwdata, hrdata, q;
  int n_mismatch = 0;
  int samples_checked = 0;
  transceiver_mode_config_regs u_dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
    .hresp(hresp), .hrdata(hrdata), .chip_operating_mode(com), .op_mode_valid(mv), .op_sleep_en(sl),
    .op_standby_en(sb), .op_synth_en(sy), .op_receive_en(rx), .op_transmit_en(tx), .frequency_band_select(band),
    .band_alt_en(b_alt), .band_reserved_flag(b_res), .vco_tune_trim(trim), .pll_divider_group_one(g1),
    .pll_divider_group_two(g2), .modulation_type_select(mod), .fsk_en(fsk), .ook_en(ook),
    .modulation_reserved_flag(mres), .onoff_threshold_type(thr), .intermediate_freq_gain(gain),
    .data_continuous_en(dc), .data_buffered_en(db), .data_packet_en(dp));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Single AHB transfer; waits are bounded so a stuck slave ends the run
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    do begin @(posedge core_clk); n++; end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin n_mismatch++; wrap_up(); end
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge core_clk); n++; end while (rdy !== 1'b1 && n < 100);
    q = hrdata;
    if (rdy !== 1'b1) begin n_mismatch++; wrap_up(); end
  endtask : bus
  // Write then let the registered decode settle
  task automatic put(input logic [31:0] a, input logic [7:0] v);
    bus(1'b1, a, {24'hffffff, v});
    repeat (2) @(posedge core_clk);
  endtask : put
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    bus(1'b0, addr_general_configuration, 32'h0); chk("gen reset", q, 32'h28);
    bus(1'b0, addr_data_and_modulation_configuration, 32'h0); chk("dm reset", q, 32'h88);
    chk("standby", {sl, sb, sy, rx, tx}, 5'b01000);
    chk("band trim", {band, trim}, 4'b0100);
    chk("groups", {g1, g2}, 2'b10);
    chk("resp okay", hresp, 32'h0);
    chk("dm decode", {fsk, ook, mres, dc, db, dp, thr, gain}, 10'b1001000100);
  endtask : t_reset
  // Every defined mode code, with band, trim and divider fields moved alongside
  task automatic t_modes();
    logic [7:0] w;
    for (int m = 0; m < 5; m++) begin // Reserved mode codes never written
      w = {m[2:0], (m == 4) ? 2'b11 : 2'b10, m[1:0], m[0]};
      put(addr_general_configuration, w);
      chk("mode", {mv, com, tx, rx, sy, sb, sl}, {4'h8 | m[2:0], 5'h01 << m});
      chk("band", {band, b_alt, b_res}, {w[4:3], w[4:3] == 2'b10, w[4:3] == 2'b11});
      chk("trim grp", {trim, g2, g1}, {w[2:1], w[0], !w[0]});
      bus(1'b0, addr_general_configuration, 32'h0); chk("gen read", q, {24'h0, w});
    end
  endtask : t_modes
  // Modulation and data operation codes, reserved modulation codes included
  task automatic t_datamod();
    logic [7:0] tbl [5] = '{8'h5b, 8'ha9, 8'h96, 8'he4, 8'h00};
    foreach (tbl[i]) begin
      put(addr_data_and_modulation_configuration, tbl[i]);
      chk("mod", {mod, fsk, ook, mres}, {tbl[i][7:6], tbl[i][7:6] == 2'b10, tbl[i][7:6] == 2'b01,
        tbl[i][7:6] == 2'b00 || tbl[i][7:6] == 2'b11});
      chk("data", {dc, db, dp}, {!tbl[i][2] && !tbl[i][5], !tbl[i][2] && tbl[i][5], tbl[i][2]});
      chk("thr gain", {thr, gain}, {tbl[i][4:3], tbl[i][1:0]});
      bus(1'b0, addr_data_and_modulation_configuration, 32'h0); chk("dm read", q, {24'h0, tbl[i]});
    end
  endtask : t_datamod
  // Unmapped place: write dropped, read zero, general configuration byte and mode untouched
  task automatic t_unmapped();
    put(32'h8, 8'hff);
    bus(1'b0, 32'h8, 32'h0); chk("unmapped", q, 32'h0);
    bus(1'b0, addr_general_configuration, 32'h0); chk("gen kept", q, 32'h98);
    chk("mode kept", com, mode_transmit);
  endtask : t_unmapped
  // Reset in mid-run brings the mode decode and the general configuration byte back to power-on values
  task automatic t_midreset();
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk("reset mode", {mv, com}, {1'b1, mode_standby});
    bus(1'b0, addr_general_configuration, 32'h0); chk("gen after reset", q, 32'h28);
  endtask : t_midreset
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Main sequence
  initial begin
    reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_modes();
    t_datamod();
    t_unmapped();
    t_midreset();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
